// file: rtl/lcd_host_register_port.sv
// Host-facing register port: index/data pair and two mode-select registers.
// Assumes single-cycle byte I/O strobes on clk_sys from same-domain bus logic.
// Operation
// R1: Index pointer at 3D4H, full byte read/write
// R2: Port 3D5H accesses selected indexed register
// R3: Video enable resets zero, software sets it
// R4: Page select defaults zero, picks buffer page
// R5: Page select matters only in 200-line mode
// R6: Bit 0 selects 200 or 400 lines
// R7: Software writes zeros to reserved bits
// R8: Other registers only via index/data pair
// R9: Index pointer holds across data accesses
`timescale 1ns/10ps
module lcd_host_register_port (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_hit,
  output logic video_enable_bit,
  output logic display_page_select,
  output logic line400_select,
  output logic [19:0] display_page_base,
  output logic [14:0] display_start
);
  logic [7:0] index_address_field;
  logic [7:0] mode_a;
  logic [7:0] mode_b;
  logic [7:0] index_data_field;
  logic [7:0] next_rdata;

  // Full-width compare: the four ports must not alias on the upper address lines
  function automatic logic addr_is(
    input logic [lcd_port_pkg::ADDR_W-1:0] addr,
    input logic [lcd_port_pkg::ADDR_W-1:0] target
  );
    return addr == target;
  endfunction : addr_is

  wire sel_index = addr_is(io_addr, lcd_port_pkg::ADDR_INDEX);
  wire sel_data = addr_is(io_addr, lcd_port_pkg::ADDR_DATA);
  wire sel_mode_a = addr_is(io_addr, lcd_port_pkg::ADDR_MODE_A);
  wire sel_mode_b = addr_is(io_addr, lcd_port_pkg::ADDR_MODE_B);
  wire any_sel = sel_index | sel_data | sel_mode_a | sel_mode_b;
  wire data_wr = io_wr & sel_data;

  lcd_indexed_regs #(.DEPTH(256)) u_idx (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_en(data_wr), // [R2] [R8]
    .index_address_field(index_address_field),
    .wr_data(io_wdata),
    .rd_data(index_data_field),
    .display_start(display_start)
  );

  // Reserved bits are stored as written; software keeps them zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      index_address_field <= lcd_port_pkg::INDEX_RESET;
      mode_a <= lcd_port_pkg::MODE_A_RESET; // [R3]
      mode_b <= lcd_port_pkg::MODE_B_RESET; // [R4] [R6]
      io_rdata <= 8'h00;
    end else begin
      if (io_wr && sel_index) index_address_field <= io_wdata; // [R1] [R9]
      if (io_wr && sel_mode_a) mode_a <= io_wdata; // [R7]
      if (io_wr && sel_mode_b) mode_b <= io_wdata; // [R7]
      if (io_rd) io_rdata <= next_rdata;
    end
  end

  // Unmapped addresses read as zero and do not claim the cycle
  always_comb begin
    if (sel_index) next_rdata = index_address_field; // [R1] [R9]
    else if (sel_data) next_rdata = index_data_field; // [R2]
    else if (sel_mode_a) next_rdata = mode_a;
    else if (sel_mode_b) next_rdata = mode_b;
    else next_rdata = 8'h00;
  end

  assign io_hit = (io_rd | io_wr) & any_sel;
  assign video_enable_bit = mode_a[lcd_port_pkg::VIDEO_ENABLE_POS]; // [R3]
  assign line400_select = mode_b[lcd_port_pkg::LINE400_POS]; // [R6]
  assign display_page_select = mode_b[lcd_port_pkg::PAGE_SELECT_POS];
  // In 400-line mode the whole buffer is used, so page 0 base is fixed
  assign display_page_base = (!line400_select && display_page_select) ?
      lcd_port_pkg::PAGE1_BASE : lcd_port_pkg::PAGE0_BASE; // [R4] [R5]

  // Readback is checked through stored state, so any spacing of host cycles is covered
  property p_index_rw;
    @(posedge clk_sys) disable iff (srst)
      io_rd && sel_index |=> io_rdata == $past(index_address_field);
  endproperty
  a_index_rw: assert property (p_index_rw) else $error("index readback wrong"); // [R1]

  property p_index_take;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_index |=> index_address_field == $past(io_wdata);
  endproperty
  a_index_take: assert property (p_index_take) else $error("index write lost"); // [R1]

  property p_index_hold;
    @(posedge clk_sys) disable iff (srst)
      !(io_wr && sel_index) |=> index_address_field == $past(index_address_field);
  endproperty
  a_index_hold: assert property (p_index_hold) else $error("index changed"); // [R9]

  property p_data_rw;
    @(posedge clk_sys) disable iff (srst)
      io_rd && sel_data |=> io_rdata == $past(index_data_field);
  endproperty
  a_data_rw: assert property (p_data_rw) else $error("indexed data wrong"); // [R2]

  property p_data_take;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_data |=> index_data_field == $past(io_wdata);
  endproperty
  a_data_take: assert property (p_data_take) else $error("indexed write lost"); // [R2]

  property p_video_enable_bit_reset;
    @(posedge clk_sys) $fell(srst) |-> !video_enable_bit;
  endproperty
  a_video_enable_bit_reset: assert property (p_video_enable_bit_reset) else $error("video on after reset"); // [R3]

  property p_video_enable_bit_write;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_mode_a |=>
        video_enable_bit == $past(io_wdata[lcd_port_pkg::VIDEO_ENABLE_POS]);
  endproperty
  a_video_enable_bit_write: assert property (p_video_enable_bit_write) else $error("video bit not taken"); // [R3]

  property p_page;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_mode_b && io_wdata[lcd_port_pkg::PAGE_SELECT_POS] &&
        !io_wdata[lcd_port_pkg::LINE400_POS] |=>
        display_page_base == lcd_port_pkg::PAGE1_BASE;
  endproperty
  a_page: assert property (p_page) else $error("page 1 not shown"); // [R4]

  property p_page_ignored;
    @(posedge clk_sys) disable iff (srst)
      line400_select |-> display_page_base == lcd_port_pkg::PAGE0_BASE;
  endproperty
  a_page_ignored: assert property (p_page_ignored) else $error("page used in 400"); // [R5]

  property p_line400;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_mode_b |=> line400_select == $past(io_wdata[lcd_port_pkg::LINE400_POS]);
  endproperty
  a_line400: assert property (p_line400) else $error("line mode not taken"); // [R6]

  property p_mode_isolated;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_data |=> $stable(mode_a) && $stable(mode_b);
  endproperty
  a_mode_isolated: assert property (p_mode_isolated) else $error("data hit mode reg"); // [R8]

  property p_page_select_take;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_mode_b |=>
        display_page_select == $past(io_wdata[lcd_port_pkg::PAGE_SELECT_POS]);
  endproperty
  a_page_select_take: assert property (p_page_select_take) else $error("page bit lost"); // [R4]

  property p_page0;
    @(posedge clk_sys) disable iff (srst)
      io_wr && sel_mode_b && !io_wdata[lcd_port_pkg::PAGE_SELECT_POS] |=>
        display_page_base == lcd_port_pkg::PAGE0_BASE;
  endproperty
  a_page0: assert property (p_page0) else $error("page 0 not shown"); // [R4]

  property p_mode_a_rd;
    @(posedge clk_sys) disable iff (srst)
      io_rd && sel_mode_a |=> io_rdata == $past(mode_a);
  endproperty
  a_mode_a_rd: assert property (p_mode_a_rd) else $error("mode A readback wrong"); // [R3]

  property p_mode_b_rd;
    @(posedge clk_sys) disable iff (srst)
      io_rd && sel_mode_b |=> io_rdata == $past(mode_b);
  endproperty
  a_mode_b_rd: assert property (p_mode_b_rd) else $error("mode B readback wrong"); // [R6]

  // Read data must stand until the host reads again
  property p_rdata_hold;
    @(posedge clk_sys) disable iff (srst)
      !io_rd |=> $stable(io_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // [R2]

  // Unmapped cycles are refused outright: nothing stored, zero returned
  property p_unmapped_read;
    @(posedge clk_sys) disable iff (srst)
      io_rd && !any_sel |=> io_rdata == '0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read data"); // [R8]

  property p_unmapped_write;
    @(posedge clk_sys) disable iff (srst)
      io_wr && !any_sel |=>
        $stable(mode_a) && $stable(mode_b) && $stable(index_address_field);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write"); // [R8]

  property p_start_isolated;
    @(posedge clk_sys) disable iff (srst)
      io_wr && !sel_data |=> $stable(display_start);
  endproperty
  a_start_isolated: assert property (p_start_isolated) else $error("start moved"); // [R8]

  // Reset values are checked at the first edge after release
  property p_mode_b_reset;
    @(posedge clk_sys) $fell(srst) |->
      !display_page_select && !line400_select &&
      display_page_base == lcd_port_pkg::PAGE0_BASE;
  endproperty
  a_mode_b_reset: assert property (p_mode_b_reset) else $error("mode B not reset"); // [R4] [R6]

  property p_index_reset;
    @(posedge clk_sys) $fell(srst) |-> index_address_field == lcd_port_pkg::INDEX_RESET;
  endproperty
  a_index_reset: assert property (p_index_reset) else $error("index not reset"); // [R1]

  c_video_enable_bit_on: cover property (@(posedge clk_sys) $rose(video_enable_bit));
  c_line400: cover property (@(posedge clk_sys) $rose(line400_select));
  c_page1: cover property (@(posedge clk_sys) display_page_base == lcd_port_pkg::PAGE1_BASE);
  c_idx_rd: cover property (@(posedge clk_sys) io_rd && sel_data);
  c_unmapped: cover property (@(posedge clk_sys) io_rd && !any_sel);
endmodule : lcd_host_register_port

// file: rtl/lcd_indexed_regs.sv
// Indexed register space reached through the index/data port pair.
// Assumes the parent supplies a decoded write strobe and the current index.
`timescale 1ns/10ps
module lcd_indexed_regs #(
  parameter int DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [7:0] index_address_field,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [14:0] display_start
);
  // An 8-bit index reaches exactly 256 words; any other depth leaves holes
  if (DEPTH != 256) begin : g_depth_check
    $error("lcd_indexed_regs: DEPTH must be 256");
  end
  logic [7:0] regs [0:DEPTH-1];
  // Whole array clears on reset so unread indexes never return unknowns
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < DEPTH; i++) regs[i] <= lcd_port_pkg::INDEXED_RESET;
    end else if (wr_en) begin
      regs[index_address_field] <= wr_data;
    end
  end
  assign rd_data = regs[index_address_field];
  assign display_start = {regs[lcd_port_pkg::IDX_START_HI][6:0],
                          regs[lcd_port_pkg::IDX_START_LO]};
endmodule : lcd_indexed_regs

// file: rtl/lcd_port_pkg.sv
// Constants for the host register port of the LCD controller unit.
// Assumes byte-wide I/O cycles already decoded to a 16-bit I/O address.
package lcd_port_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] ADDR_INDEX = 16'h03D4;
  localparam logic [15:0] ADDR_DATA = 16'h03D5;
  localparam logic [15:0] ADDR_MODE_A = 16'h03D8;
  localparam logic [15:0] ADDR_MODE_B = 16'h03DE;
  localparam int VIDEO_ENABLE_POS = 3;
  localparam int PAGE_SELECT_POS = 3;
  localparam int LINE400_POS = 0;
  localparam logic [7:0] MODE_A_RESET = 8'h00;
  localparam logic [7:0] MODE_B_RESET = 8'h00;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] INDEXED_RESET = 8'h00;
  localparam logic [7:0] IDX_START_HI = 8'h0C;
  localparam logic [7:0] IDX_START_LO = 8'h0D;
  localparam logic [7:0] IDX_TIMING_FIRST = 8'hC6;
  localparam logic [7:0] IDX_TIMING_LAST = 8'hCC;
  localparam logic [19:0] PAGE0_BASE = 20'hB8000;
  localparam logic [19:0] PAGE1_BASE = 20'hBC000;
endpackage : lcd_port_pkg

// file: verif/host_io.sv
// Host processor model: byte I/O write and read cycles to the port.
// Assumes reads answer one cycle after the strobe edge.
`timescale 1ns/10ps
module host_io (
  input wire logic clk_sys,
  input wire logic [7:0] io_rdata,
  output logic io_wr,
  output logic io_rd,
  output logic [15:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
  end
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) #1;
    io_wr = 1'b1;
    io_addr = a;
    io_wdata = d;
    @(posedge clk_sys) #1;
    io_wr = 1'b0;
    // Released bus shows junk so stale values cannot pass
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : wr
  task rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk_sys) #1;
    io_rd = 1'b1;
    io_addr = a;
    @(posedge clk_sys) #1;
    io_rd = 1'b0;
    io_addr = ~io_addr;
    q = io_rdata;
  endtask : rd
endmodule : host_io

// file: verif/lcd_host_register_port_bench.sv
// Bench for the host register port: table of byte cycles, then hand tests.
// Assumes host_io drives the bus and all register bits read back.
`timescale 1ns/10ps
module lcd_host_register_port_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic io_wr, io_rd, io_hit, video_enable_bit, display_page_select, line400_select;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, q;
  logic [19:0] display_page_base;
  logic [14:0] display_start;
  int mismatches = 0;
  int check_count = 0;
  logic last_hit = 1'b0;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e; logic h;} row_t;
  row_t rows[4] = '{'{16'h03D4, 8'hA5, 8'hA5, 1'b1}, '{16'h03D8, 8'h08, 8'h08, 1'b1},
    '{16'h03DE, 8'h09, 8'h09, 1'b1}, '{16'h03D9, 8'hFF, 8'h00, 1'b0}};
  always #2 clk_sys = ~clk_sys;
  // The hit flag only stands during a strobe, so it is caught at the sampling edge
  always @(posedge clk_sys) if (io_wr || io_rd) last_hit <= io_hit;
  lcd_host_register_port lcd_host_register_port_inst (.clk_sys(clk_sys), .srst(srst),
    .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .video_enable_bit(video_enable_bit),
    .display_page_select(display_page_select), .line400_select(line400_select),
    .display_page_base(display_page_base), .display_start(display_start));
  host_io host_io_inst (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_wr(io_wr),
    .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata));
  task chk(input logic [19:0] g, input logic [19:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rdchk(input logic [15:0] a, input logic [7:0] e);
    host_io_inst.rd(a, q);
    chk({12'h000, q}, {12'h000, e});
  endtask : rdchk
  task final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 srst = 1'b0;
    chk(display_page_base, 20'hB8000);
    chk({19'h00000, video_enable_bit}, 20'h00000);
    rdchk(16'h03DE, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      host_io_inst.wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
      chk({19'h00000, last_hit}, {19'h00000, rows[i].h});
    end
    chk({19'h00000, video_enable_bit}, 20'h00001);
    chk(display_page_base, 20'hB8000);
    $display("table test done");
    host_io_inst.wr(16'h03D4, 8'h0C);
    host_io_inst.wr(16'h03D5, 8'h55);
    host_io_inst.wr(16'h03D4, 8'h0D);
    host_io_inst.wr(16'h03D5, 8'hA8);
    rdchk(16'h03D5, 8'hA8);
    chk({5'h00, display_start}, 20'h055A8);
    host_io_inst.wr(16'h03D4, 8'h0C);
    rdchk(16'h03D4, 8'h0C);
    rdchk(16'h03D5, 8'h55);
    rdchk(16'h03D4, 8'h0C);
    $display("index test done");
    host_io_inst.wr(16'h03DE, 8'h08);
    chk({18'h00000, display_page_select, line400_select}, 20'h00002);
    chk(display_page_base, 20'hBC000);
    host_io_inst.wr(16'h03DE, 8'h00);
    chk(display_page_base, 20'hB8000);
    $display("page test done");
    host_io_inst.wr(16'h03D8, 8'h08);
    @(posedge clk_sys) #1 srst = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 srst = 1'b0;
    chk({19'h00000, video_enable_bit}, 20'h00000);
    chk({5'h00, display_start}, 20'h00000);
    rdchk(16'h03D4, 8'h00);
    $display("mid-run reset test done");
    final_report();
  end
endmodule : lcd_host_register_port_bench
